// ==== verilog/ctu_pkg.sv ====
package ctu_pkg;

	// ==========================================================
	// Register map
	localparam logic [15:0] CTU_CTRL_OFFSET = 16'hA200;
	localparam logic [15:0] CTU_CLR_DELTA = 16'h0004;
	localparam logic [15:0] CTU_SET_DELTA = 16'h0008;
	localparam logic [15:0] CTU_INV_DELTA = 16'h000C;
	localparam logic [31:0] CTU_CTRL_RESET = 32'h00000000;
	localparam logic [31:0] CTU_CTRL_MASK = 32'hFFFCBFFF;

	// ==========================================================
	// Field positions
	localparam int CTU_E1_MODE_BIT = 31;
	localparam int CTU_E1_POL_BIT = 30;
	localparam int CTU_E1_SEL_LSB = 26;
	localparam int CTU_E2_SEEN_BIT = 25;
	localparam int CTU_E1_SEEN_BIT = 24;
	localparam int CTU_E2_MODE_BIT = 23;
	localparam int CTU_E2_POL_BIT = 22;
	localparam int CTU_E2_SEL_LSB = 18;
	localparam int CTU_ON_BIT = 15;
	localparam int CTU_IDLE_STOP_BIT = 13;
	localparam int CTU_DELAY_GEN_BIT = 12;
	localparam int CTU_EDGE_GATE_BIT = 11;
	localparam int CTU_ORDER_BIT = 10;
	localparam int CTU_DISCHARGE_BIT = 9;
	localparam int CTU_TRIG_BIT = 8;
	localparam int CTU_TRIM_LSB = 2;
	localparam int CTU_RANGE_LSB = 0;
	localparam int CTU_SEL_W = 4;
	localparam int CTU_TRIM_W = 6;
	localparam int CTU_RANGE_W = 2;
	localparam int CTU_PIN_COUNT = 13;

	// ==========================================================
	// AHB-Lite encodings
	localparam logic [1:0] CTU_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] CTU_HTRANS_SEQ = 2'h3;

	typedef enum logic [1:0]
	{
		CTU_BASE = 2'h0,
		CTU_CLR = 2'h1,
		CTU_SET = 2'h2,
		CTU_INV = 2'h3
	} ctu_alias_t;

	// Measurement phase, Gray coded along idle -> charge -> done
	typedef enum logic [1:0]
	{
		CTU_ST_IDLE = 2'h0,
		CTU_ST_CHARGE = 2'h1,
		CTU_ST_DONE = 2'h3
	} ctu_state_t;

endpackage : ctu_pkg

// ==== verilog/ctu_sync.sv ====
module ctu_sync
	import ctu_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			meta_reg <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule : ctu_sync

// ==== verilog/ctu_edge_qual.sv ====
module ctu_edge_qual
	import ctu_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic sample,
	input wire logic sense_mode,
	input wire logic polarity,
	output logic hit
);

	logic prev_reg;

	// History runs even while gated, so opening the gate makes no false edge
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			prev_reg <= 1'b0;
		else
			prev_reg <= sample;
	end

	always_comb
	begin
		if (sense_mode)
			hit = polarity ? (sample & ~prev_reg) : (~sample & prev_reg);
		else
			hit = polarity ? sample : ~sample;
	end

endmodule : ctu_edge_qual

// ==== verilog/ctu_top.sv ====
module ctu_top
	import ctu_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic timer_event,
	input wire logic compare_one_event,
	input wire logic capture_one_event,
	input wire logic capture_two_event,
	input wire logic capture_three_event,
	input wire logic [CTU_PIN_COUNT-1:0] edge_input_pin,
	input wire logic comparator_one_out,
	input wire logic comparator_two_out,
	input wire logic comparator_three_out,
	input wire logic idle_mode,
	output logic unit_active,
	output logic current_source_on,
	output logic source_discharge,
	output logic [CTU_TRIM_W-1:0] current_trim,
	output logic [CTU_RANGE_W-1:0] current_range,
	output logic delay_pulse,
	output logic trigger_out
);

	// ==========================================================
	// Address decode
	function automatic logic ctu_hit_map(input logic [31:0] addr);
		logic [15:0] delta;
		delta = addr[15:0] - CTU_CTRL_OFFSET;
		ctu_hit_map = (addr[31:16] == 16'h0000) && (addr[1:0] == 2'h0)
			&& (addr[15:0] >= CTU_CTRL_OFFSET) && (delta <= CTU_INV_DELTA);
	endfunction : ctu_hit_map

	function automatic ctu_alias_t ctu_alias_of(input logic [31:0] addr);
		logic [15:0] delta;
		delta = addr[15:0] - CTU_CTRL_OFFSET;
		ctu_alias_of = ctu_alias_t'(delta[3:2]);
	endfunction : ctu_alias_of

	// ==========================================================
	// Bus slave
	logic ctrl_reg_sel;
	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;
	logic wr_pend_reg;
	logic rd_pend_reg;
	logic wr_map_reg;
	ctu_alias_t wr_alias_reg;
	logic rd_map_reg;
	ctu_alias_t rd_alias_reg;
	logic accept;
	logic first_hit;
	logic second_hit;
	logic second_take;

	assign ctrl_reg_sel = hsel && hready
		&& (htrans == CTU_HTRANS_NONSEQ || htrans == CTU_HTRANS_SEQ);
	assign accept = ctrl_reg_sel;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			wr_map_reg <= 1'b0;
			rd_map_reg <= 1'b0;
			wr_alias_reg <= CTU_BASE;
			rd_alias_reg <= CTU_BASE;
		end
		else
		begin
			wr_pend_reg <= accept && hwrite;
			rd_pend_reg <= accept && !hwrite;
			if (accept)
			begin
				wr_map_reg <= ctu_hit_map(haddr);
				rd_map_reg <= ctu_hit_map(haddr);
				wr_alias_reg <= ctu_alias_of(haddr);
				rd_alias_reg <= ctu_alias_of(haddr);
			end
		end
	end

	// Reads take one wait state so that a write just before is seen
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hreadyout <= 1'b1;
		else if (accept && !hwrite)
			hreadyout <= 1'b0;
		else
			hreadyout <= 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (rd_pend_reg)
		begin
			if (rd_map_reg && rd_alias_reg == CTU_BASE)
				hrdata <= ctrl_reg & CTU_CTRL_MASK;
			else
				hrdata <= 32'h00000000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hresp <= 1'b0;
		else
			hresp <= 1'b0;
	end

	// ==========================================================
	// Control register
	always_comb
	begin
		ctrl_next = ctrl_reg;
		if (wr_pend_reg && wr_map_reg)
		begin
			case (wr_alias_reg)
				CTU_BASE: ctrl_next = hwdata;
				CTU_CLR: ctrl_next = ctrl_reg & ~hwdata;
				CTU_SET: ctrl_next = ctrl_reg | hwdata;
				CTU_INV: ctrl_next = ctrl_reg ^ hwdata;
				default: ctrl_next = ctrl_reg;
			endcase
		end
		// Hardware set wins over a clear in the same cycle
		if (first_hit)
			ctrl_next[CTU_E1_SEEN_BIT] = 1'b1;
		if (second_take)
			ctrl_next[CTU_E2_SEEN_BIT] = 1'b1;
		ctrl_next = ctrl_next & CTU_CTRL_MASK;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ctrl_reg <= CTU_CTRL_RESET;
		else
			ctrl_reg <= ctrl_next;
	end

	// ==========================================================
	// Field views
	logic e1_mode;
	logic e1_pol;
	logic [CTU_SEL_W-1:0] e1_sel;
	logic e2_mode;
	logic e2_pol;
	logic [CTU_SEL_W-1:0] e2_sel;
	logic unit_on;
	logic idle_stop;
	logic delay_gen_enable;
	logic edge_gate_open;
	logic edge_order_enforce;
	logic trigger_out_enable;
	logic first_edge_seen;
	logic second_edge_seen;

	assign e1_mode = ctrl_reg[CTU_E1_MODE_BIT];
	assign e1_pol = ctrl_reg[CTU_E1_POL_BIT];
	assign e1_sel = ctrl_reg[CTU_E1_SEL_LSB +: CTU_SEL_W];
	assign e2_mode = ctrl_reg[CTU_E2_MODE_BIT];
	assign e2_pol = ctrl_reg[CTU_E2_POL_BIT];
	assign e2_sel = ctrl_reg[CTU_E2_SEL_LSB +: CTU_SEL_W];
	assign unit_on = ctrl_reg[CTU_ON_BIT];
	assign idle_stop = ctrl_reg[CTU_IDLE_STOP_BIT];
	assign delay_gen_enable = ctrl_reg[CTU_DELAY_GEN_BIT];
	assign edge_gate_open = ctrl_reg[CTU_EDGE_GATE_BIT];
	assign edge_order_enforce = ctrl_reg[CTU_ORDER_BIT];
	assign trigger_out_enable = ctrl_reg[CTU_TRIG_BIT];
	assign first_edge_seen = ctrl_reg[CTU_E1_SEEN_BIT];
	assign second_edge_seen = ctrl_reg[CTU_E2_SEEN_BIT];

	// ==========================================================
	// Input conditioning
	localparam int ASYNC_W = CTU_PIN_COUNT + 4;
	logic [ASYNC_W-1:0] async_raw;
	logic [ASYNC_W-1:0] async_sync;
	logic idle_sync;
	logic [CTU_PIN_COUNT-1:0] pin_s;
	logic c1_s;
	logic c2_s;
	logic c3_s;
	logic bus_clk_phase_reg;

	assign async_raw = {idle_mode, comparator_three_out, comparator_two_out, comparator_one_out,
		edge_input_pin};

	ctu_sync #(
		.WIDTH(ASYNC_W)
	) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in(async_raw),
		.sync_out(async_sync)
	);

	assign pin_s = async_sync[CTU_PIN_COUNT-1:0];
	assign c1_s = async_sync[CTU_PIN_COUNT];
	assign c2_s = async_sync[CTU_PIN_COUNT+1];
	assign c3_s = async_sync[CTU_PIN_COUNT+2];
	assign idle_sync = async_sync[CTU_PIN_COUNT+3];

	// Bus clock as a source is seen as a half-rate square wave of hclk
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			bus_clk_phase_reg <= 1'b0;
		else
			bus_clk_phase_reg <= ~bus_clk_phase_reg;
	end

	// ==========================================================
	// Source selection
	logic [15:0] e1_sources;
	logic [15:0] e2_sources;
	logic e1_sample;
	logic e2_sample;

	assign e1_sources = {c3_s, c2_s, c1_s, capture_three_event, capture_two_event, capture_one_event,
		pin_s[7:2], pin_s[0], pin_s[1], compare_one_event, timer_event};
	assign e2_sources = {c3_s, c2_s, c1_s, bus_clk_phase_reg, capture_three_event,
		capture_two_event, capture_one_event, pin_s[12:8], pin_s[0], pin_s[1],
		compare_one_event, timer_event};
	assign e1_sample = e1_sources[e1_sel];
	assign e2_sample = e2_sources[e2_sel];

	// ==========================================================
	// Edge qualification
	logic e1_qual;
	logic e2_qual;
	logic run;

	ctu_edge_qual u_first_edge (
		.hclk(hclk),
		.hresetn(hresetn),
		.sample(e1_sample),
		.sense_mode(e1_mode),
		.polarity(e1_pol),
		.hit(e1_qual)
	);

	ctu_edge_qual u_second_edge (
		.hclk(hclk),
		.hresetn(hresetn),
		.sample(e2_sample),
		.sense_mode(e2_mode),
		.polarity(e2_pol),
		.hit(e2_qual)
	);

	assign run = unit_on && !(idle_stop && idle_sync);
	assign first_hit = run && edge_gate_open && e1_qual;
	assign second_hit = run && edge_gate_open && e2_qual;
	assign second_take = second_hit && (!edge_order_enforce || first_edge_seen);

	// ==========================================================
	// Measurement phase
	ctu_state_t state_reg;
	ctu_state_t state_next;

	always_comb
	begin
		case (state_reg)
			CTU_ST_IDLE:
				state_next = !ctrl_next[CTU_E1_SEEN_BIT] ? CTU_ST_IDLE
					: (ctrl_next[CTU_E2_SEEN_BIT] ? CTU_ST_DONE : CTU_ST_CHARGE);
			CTU_ST_CHARGE:
				if (!ctrl_next[CTU_E1_SEEN_BIT])
					state_next = CTU_ST_IDLE;
				else if (ctrl_next[CTU_E2_SEEN_BIT])
					state_next = CTU_ST_DONE;
				else
					state_next = CTU_ST_CHARGE;
			CTU_ST_DONE:
				state_next = ctrl_next[CTU_E2_SEEN_BIT] ? CTU_ST_DONE : CTU_ST_IDLE;
			default:
				state_next = CTU_ST_IDLE;
		endcase
		if (!run)
			state_next = CTU_ST_IDLE;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state_reg <= CTU_ST_IDLE;
		else
			state_reg <= state_next;
	end

	// ==========================================================
	// Outputs toward the analog side and other modules
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			unit_active <= 1'b0;
		else
			unit_active <= run;
	end

	// Source charges between the first and second edge
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			current_source_on <= 1'b0;
		else
			current_source_on <= (state_next == CTU_ST_CHARGE);
	end

	// Grounding the source is for capacitor discharge, timing is left to software
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			source_discharge <= 1'b0;
		else
			source_discharge <= ctrl_reg[CTU_DISCHARGE_BIT];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			current_trim <= '0;
			current_range <= '0;
		end
		else
		begin
			current_trim <= ctrl_reg[CTU_TRIM_LSB +: CTU_TRIM_W];
			current_range <= ctrl_reg[CTU_RANGE_LSB +: CTU_RANGE_W];
		end
	end

	// Delay pulse spans first edge to second edge; second source should be comparator two
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			delay_pulse <= 1'b0;
		else
			delay_pulse <= delay_gen_enable && (state_next == CTU_ST_CHARGE);
	end

	// One-cycle trigger when a measurement completes
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			trigger_out <= 1'b0;
		else
			trigger_out <= trigger_out_enable && second_take && !second_edge_seen;
	end

endmodule : ctu_top

// ==== dv/ctu_events.sv ====
module ctu_events
	import ctu_pkg::*;
(
	input wire logic hclk,
	input wire logic [20:0] want,
	output logic timer_event,
	output logic compare_one_event,
	output logic capture_one_event,
	output logic capture_two_event,
	output logic capture_three_event,
	output logic [CTU_PIN_COUNT-1:0] edge_input_pin,
	output logic comparator_one_out,
	output logic comparator_two_out,
	output logic comparator_three_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// =====
	// Sources
	always_ff @(posedge hclk)
	begin
		{capture_three_event, capture_two_event, capture_one_event, compare_one_event, timer_event} <= want[4:0];
	end
	// Off-grid delay so pins and comparators really reach the synchronisers asynchronously
	always @(want)
	begin
		{comparator_three_out, comparator_two_out, comparator_one_out, edge_input_pin} <= #17 want[20:5];
	end
endmodule : ctu_events

// ==== dv/ctu_asserts.sv ====
module ctu_checker
	import ctu_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic unit_active,
	input wire logic current_source_on,
	input wire logic [CTU_TRIM_W-1:0] current_trim,
	input wire logic delay_pulse,
	input wire logic trigger_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// =====
	// Bus and edge checks
	default clocking dc @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	logic taken;
	assign taken = hsel && hready && htrans[1];
	reset_quiet_a: assert property ($rose(hresetn) |-> !unit_active && hreadyout && current_trim == '0)
		else $error("outputs busy after reset");
	resp_okay_a: assert property (hresp == 1'h0)
		else $error("response not okay");
	read_wait_a: assert property (taken && !hwrite |=> !hreadyout)
		else $error("read not stalled");
	wait_once_a: assert property (!hreadyout |=> hreadyout)
		else $error("stall too long");
	write_flow_a: assert property (taken && hwrite |=> hreadyout)
		else $error("write stalled");
	trig_pulse_a: assert property (trigger_out |=> !trigger_out)
		else $error("trigger wider than a cycle");
	trig_end_a: assert property ($rose(trigger_out) |-> !current_source_on)
		else $error("charge outlives second edge");
	delay_charge_a: assert property (delay_pulse |-> current_source_on)
		else $error("delay outside charge");
	charge_run_a: assert property ($rose(current_source_on) |-> unit_active)
		else $error("charge while stopped");
	cover property (trigger_out);
	cover property ($rose(current_source_on));
	cover property (taken && !hwrite);
endmodule : ctu_checker

bind ctu_top ctu_checker chk_u
(
	.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .unit_active,
	.current_source_on, .current_trim, .delay_pulse, .trigger_out
);

// ==== dv/charge_time_edge_control_bench.sv ====
module charge_time_edge_control_bench
	import ctu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] BASE = 32'h0000A200;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, idle_mode, unit_active, current_source_on, pol;
	logic delay_pulse, trigger_out, timer_event, compare_one_event, capture_one_event, capture_two_event;
	logic capture_three_event, comparator_one_out, comparator_two_out, comparator_three_out, source_discharge;
	logic [CTU_PIN_COUNT-1:0] edge_input_pin;
	logic [CTU_TRIM_W-1:0] current_trim;
	logic [1:0] htrans, current_range, op, ex;
	logic [2:0] hsize;
	logic [20:0] want;
	logic [31:0] haddr, hwdata, hrdata, rd, wd, exp_reg;
	int num_errors = 0;
	int num_checks = 0;
	int trig_count = 0;

	ctu_top dut_u
	(
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .timer_event, .compare_one_event, .capture_one_event, .capture_two_event,
		.capture_three_event, .edge_input_pin, .comparator_one_out, .comparator_two_out, .comparator_three_out,
		.idle_mode, .unit_active, .current_source_on, .source_discharge, .current_trim, .current_range,
		.delay_pulse, .trigger_out
	);
	ctu_events src_u
	(
		.hclk, .want, .timer_event, .compare_one_event, .capture_one_event, .capture_two_event,
		.capture_three_event, .edge_input_pin, .comparator_one_out, .comparator_two_out, .comparator_three_out
	);

	initial
	begin
		hclk = 1'h0;
		forever #25 hclk = ~hclk;
	end
	always @(posedge hclk)
		if (trigger_out === 1'h1)
			trig_count++;

	// =====
	// Helpers
	function automatic int src_idx(input logic second, input logic [3:0] code);
		if (code < 4'h2 || code > 4'hC)
			return (code < 4'h2) ? int'(code) : int'(code) + 5;
		if (code < 4'h4)
			return (code == 4'h2) ? 6 : 5;
		if (second)
			return (code > 4'h8) ? int'(code) - 7 : int'(code) + 9;
		return (code > 4'h9) ? int'(code) - 8 : int'(code) + 3;
	endfunction : src_idx

	// The idle edge watches the timer rising, so edge sensing never fires on a quiet source
	function automatic logic [31:0] edge_cfg(input logic second, input logic [3:0] code, input logic [1:0] mp);
		return 32'h00008800 | (second ? {6'h30, 2'h0, mp, code, 18'h0} : {mp, code, 2'h0, 6'h30, 18'h0});
	endfunction : edge_cfg

	function automatic logic [31:0] alias_next(input logic [31:0] cur, input logic [1:0] o, input logic [31:0] d);
		case (o)
			2'h0: return d & 32'hFFFCBFFF;
			2'h1: return cur & ~d;
			2'h2: return (cur | d) & 32'hFFFCBFFF;
			default: return (cur ^ d) & 32'hFFFCBFFF;
		endcase
	endfunction : alias_next

	task close_out;
		if (num_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out

	task check(input string what, input logic [31:0] e, input logic [31:0] got);
		num_checks++;
		if (got !== e)
		begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, e, got);
		end
	endtask : check

	task wait_ready;
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'h1 && n < 20);
		if (hreadyout !== 1'h1)
		begin
			num_errors++;
			close_out();
		end
	endtask : wait_ready

	task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		htrans <= CTU_HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= wr;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
	endtask : bus

	task try_edge(input int idx, input logic [31:0] c, input logic pre, input logic post, input logic [1:0] st);
		// Unit off first, so a level-sensing setup left from the last case cannot set status while sources move
		bus(1'h1, BASE, 32'h0);
		want <= 21'(pre) << idx;
		repeat (6) @(posedge hclk);
		bus(1'h1, BASE, c);
		repeat (6) @(posedge hclk);
		want[idx] <= post;
		repeat (6) @(posedge hclk);
		bus(1'h0, BASE, 32'h0);
		check("edge status", {30'h0, st}, {30'h0, rd[25:24]});
	endtask : try_edge

	// =====
	// Sequence
	initial
	begin
		hresetn = 1'h0;
		hsel = 1'h1;
		hwrite = 1'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		want = '0;
		idle_mode = 1'h0;
		exp_reg = 32'h0;
		void'($urandom(32'h9CD83F29));
		repeat (6) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		bus(1'h0, BASE, 32'h0);
		check("reset value", 32'h0, rd);
		// Unit kept off so only software moves the status bits
		for (int i = 0; i < 16; i++)
		begin
			op = 2'($urandom_range(3));
			wd = $urandom() & 32'hFFFF7FFF;
			bus(1'h1, BASE + {28'h0, op, 2'h0}, wd);
			exp_reg = alias_next(exp_reg, op, wd);
			bus(1'h0, BASE, 32'h0);
			check("control", exp_reg, rd);
			check("trim", {24'h0, exp_reg[7:0]}, {24'h0, current_trim, current_range});
			check("discharge", {31'h0, exp_reg[9]}, {31'h0, source_discharge});
		end
		bus(1'h1, BASE + 32'h10, 32'hFFFFFFFF);
		bus(1'h0, BASE + 32'h10, 32'h0);
		check("unmapped", 32'h0, rd);
		bus(1'h0, BASE, 32'h0);
		check("control kept", exp_reg, rd);
		for (int s = 0; s < 2; s++)
			for (int c = 0; c < 16; c++)
				if (s == 0 || c != 12)
				begin
					pol = 1'($urandom_range(1));
					ex = s ? {1'h1, c == 0 && pol} : {c == 0 && pol, 1'h1};
					try_edge(src_idx(s[0], c[3:0]), edge_cfg(s[0], c[3:0], {1'h1, pol}), !pol, pol, ex);
				end
		try_edge(0, 32'h40C08800, 1'h1, 1'h1, 2'h1);
		try_edge(0, 32'hC0C08800, 1'h1, 1'h1, 2'h0);
		try_edge(0, 32'hC0C08800, 1'h1, 1'h0, 2'h0);
		try_edge(0, 32'hC0C08000, 1'h0, 1'h1, 2'h0);
		try_edge(0, 32'hC0C00800, 1'h0, 1'h1, 2'h0);
		try_edge(1, 32'hC0048800, 1'h0, 1'h0, 2'h2);
		try_edge(1, 32'hC0848800, 1'h1, 1'h0, 2'h2);
		try_edge(1, 32'hC0C48C00, 1'h0, 1'h1, 2'h0);
		try_edge(0, 32'hC0F08800, 1'h0, 1'h0, 2'h2);
		idle_mode <= 1'h1;
		try_edge(0, 32'hC0C0A800, 1'h0, 1'h1, 2'h0);
		check("idle stop", 32'h0, {31'h0, unit_active});
		idle_mode <= 1'h0;
		try_edge(0, 32'hC0C0A800, 1'h0, 1'h1, 2'h3);
		try_edge(0, 32'hC0F89D00, 1'h0, 1'h1, 2'h1);
		check("charging", 32'h1, {31'h0, current_source_on & delay_pulse});
		want[19] <= 1'h1;
		repeat (8) @(posedge hclk);
		check("trigger count", 32'h1, 32'(trig_count));
		check("charge over", 32'h0, {31'h0, current_source_on | delay_pulse});
		bus(1'h0, BASE, 32'h0);
		check("ordered status", 32'h3, {30'h0, rd[25:24]});
		close_out();
	end
endmodule : charge_time_edge_control_bench
